// ===== bsc_unit.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "bsc_regs.svh"
// What this block does
// - equal registers skip next instruction, 1/2/3 cycles
// - compares subtract, discard, set ZNVCH, 1 cycle
// - register bit clear skips, flags untouched
// - register bit set skips, flags untouched
// - io bit clear skips, flags untouched
// - io bit set skips, flags untouched
// - selected status bit set branches pc+k+1
// - selected status bit clear branches, 1/2 cycles
// - carry clear branches pc+k+1
// - same-or-higher equals carry clear branch
// - signed ge branches when N xor V zero
// - signed lt branches when N xor V one
// - half carry set branches
// - half carry clear branches
// - bit store flag set branches
// - bit store flag clear branches
// - overflow set branches
module bsc_unit
  import bsc_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int OFFSET_W = 7
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // zero-width padding in sign extension and readback is illegal
  generate
    if (PC_W < 2 || PC_W > 31 || OFFSET_W < 2 || OFFSET_W >= PC_W) begin : g_bad_param
      $error("bsc_unit: PC_W must be 2..31 and OFFSET_W 2..PC_W-1");
    end
  endgenerate

  // apb access phase; one wait state so read data comes from a flop
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic access;
  logic wr_en;
  assign access = PSEL & PENABLE & ~pready_reg;
  // a write lands at the edge where the master sees ready, not earlier
  assign wr_en = PSEL & PENABLE & PWRITE & pready_reg;

  logic hit_ctrl;
  logic hit_opnd;
  logic hit_offs;
  logic hit_stat;
  logic hit_pc;
  logic hit_rslt;
  logic hit_any;
  assign hit_ctrl = (PADDR == `BSC_ADDR_CTRL);
  assign hit_opnd = (PADDR == `BSC_ADDR_OPND);
  assign hit_offs = (PADDR == `BSC_ADDR_OFFS);
  assign hit_stat = (PADDR == `BSC_ADDR_STAT);
  assign hit_pc = (PADDR == `BSC_ADDR_PC);
  assign hit_rslt = (PADDR == `BSC_ADDR_RSLT);
  assign hit_any = hit_ctrl | hit_opnd | hit_offs | hit_stat | hit_pc | hit_rslt;

  // programming state
  bsc_op_type op_reg;
  logic long_reg;
  logic [2:0] bidx_reg;
  logic [7:0] rd_val_reg;
  logic [7:0] rr_val_reg;
  logic [7:0] io_val_reg;
  logic [OFFSET_W-1:0] offs_reg;
  logic [7:0] status_register_reg;
  logic [PC_W-1:0] pc_reg;
  bsc_state_type state_reg;
  bsc_state_type state_next;
  logic taken_reg;
  logic [1:0] cyc_reg;

  logic busy;
  logic start;
  logic exec;
  assign busy = (state_reg != BSC_ST_IDLE);
  // operands may not change under a running instruction
  assign start = wr_en & hit_ctrl & PWDATA[`BSC_CTRL_START] & ~busy;
  assign exec = (state_reg == BSC_ST_EXEC);

  // operation classes
  logic is_cmp;
  logic is_skip;
  assign is_cmp = (op_reg == BSC_OP_COMPARE_REGS) |
                  (op_reg == BSC_OP_COMPARE_REGS_CARRY) |
                  (op_reg == BSC_OP_COMPARE_IMMEDIATE);
  assign is_skip = (op_reg == BSC_OP_COMPARE_SKIP_EQUAL) |
                   (op_reg == BSC_OP_SKIP_REG_BIT_CLEAR) |
                   (op_reg == BSC_OP_SKIP_REG_BIT_SET) |
                   (op_reg == BSC_OP_SKIP_IO_BIT_CLEAR) |
                   (op_reg == BSC_OP_SKIP_IO_BIT_SET);

  // selected bits of register, io byte and status register
  logic reg_bit;
  logic io_bit;
  logic sr_bit;
  bsc_bit_pick #(.W(8)) u_reg_bit (
    .value(rr_val_reg),
    .idx(bidx_reg),
    .bit_out(reg_bit)
  );
  bsc_bit_pick #(.W(8)) u_io_bit (
    .value(io_val_reg),
    .idx(bidx_reg),
    .bit_out(io_bit)
  );
  bsc_bit_pick #(.W(8)) u_sr_bit (
    .value(status_register_reg),
    .idx(bidx_reg),
    .bit_out(sr_bit)
  );

  logic flag_c;
  logic flag_h;
  logic flag_t;
  logic flag_v;
  logic signed_lt;
  assign flag_c = status_register_reg[`BSC_SR_C];
  assign flag_h = status_register_reg[`BSC_SR_H];
  assign flag_t = status_register_reg[`BSC_SR_T];
  assign flag_v = status_register_reg[`BSC_SR_V];
  assign signed_lt = status_register_reg[`BSC_SR_N] ^ status_register_reg[`BSC_SR_V];

  // condition for skip or branch
  logic cond;
  always_comb begin
    case (op_reg)
      BSC_OP_COMPARE_SKIP_EQUAL: cond = (rd_val_reg == rr_val_reg);
      BSC_OP_SKIP_REG_BIT_CLEAR: cond = ~reg_bit;
      BSC_OP_SKIP_REG_BIT_SET: cond = reg_bit;
      BSC_OP_SKIP_IO_BIT_CLEAR: cond = ~io_bit;
      BSC_OP_SKIP_IO_BIT_SET: cond = io_bit;
      BSC_OP_BRANCH_FLAG_SET: cond = sr_bit;
      BSC_OP_BRANCH_FLAG_CLEAR: cond = ~sr_bit;
      BSC_OP_BRANCH_CARRY_CLEAR: cond = ~flag_c;
      BSC_OP_BRANCH_SAME_HIGHER: cond = ~flag_c;
      BSC_OP_BRANCH_SIGNED_GE: cond = ~signed_lt;
      BSC_OP_BRANCH_SIGNED_LT: cond = signed_lt;
      BSC_OP_BRANCH_HALFCARRY_SET: cond = flag_h;
      BSC_OP_BRANCH_HALFCARRY_CLEAR: cond = ~flag_h;
      BSC_OP_BRANCH_BITSTORE_SET: cond = flag_t;
      BSC_OP_BRANCH_BITSTORE_CLEAR: cond = ~flag_t;
      BSC_OP_BRANCH_OVERFLOW_SET: cond = flag_v;
      default: cond = 1'b0;
    endcase
  end

  logic is_branch_op;
  logic taken;
  assign is_branch_op = ~is_cmp & ~is_skip & (op_reg != BSC_OP_NOP);
  // compares, nop and unknown codes never redirect the pc
  assign taken = (is_skip | is_branch_op) & cond;

  // compare flags
  logic cmp_c;
  logic cmp_z;
  logic cmp_n;
  logic cmp_v;
  logic cmp_h;
  bsc_compare u_compare (
    .a(rd_val_reg),
    .b(rr_val_reg),
    .use_carry(op_reg == BSC_OP_COMPARE_REGS_CARRY),
    .c_in(flag_c),
    .z_in(status_register_reg[`BSC_SR_Z]),
    .c_out(cmp_c),
    .z_out(cmp_z),
    .n_out(cmp_n),
    .v_out(cmp_v),
    .h_out(cmp_h)
  );

  // result discarded; S, T and I are kept as they were
  logic [7:0] status_register_cmp;
  always_comb begin
    status_register_cmp = status_register_reg;
    status_register_cmp[`BSC_SR_C] = cmp_c;
    status_register_cmp[`BSC_SR_Z] = cmp_z;
    status_register_cmp[`BSC_SR_N] = cmp_n;
    status_register_cmp[`BSC_SR_V] = cmp_v;
    status_register_cmp[`BSC_SR_H] = cmp_h;
  end

  // program counter candidates
  logic [PC_W-1:0] offs_ext;
  logic [PC_W-1:0] pc_plain;
  logic [PC_W-1:0] pc_skip;
  logic [PC_W-1:0] pc_branch;
  assign offs_ext = {{(PC_W-OFFSET_W){offs_reg[OFFSET_W-1]}}, offs_reg};
  assign pc_plain = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
  assign pc_skip = pc_reg + (long_reg ? PC_W'(3) : PC_W'(2));
  assign pc_branch = pc_reg + offs_ext + {{(PC_W-1){1'b0}}, 1'b1};

  logic [PC_W-1:0] pc_exec;
  logic [1:0] cyc_exec;
  logic [7:0] status_register_exec;
  // not taken: one word on, as for any single-cycle instruction
  assign pc_exec = !taken ? pc_plain : (is_skip ? pc_skip : pc_branch);
  assign status_register_exec = is_cmp ? status_register_cmp : status_register_reg;
  assign cyc_exec = !taken ? `BSC_CYC_PLAIN :
                    !is_skip ? `BSC_CYC_TAKEN :
                    long_reg ? `BSC_CYC_SKIP2 : `BSC_CYC_SKIP1;

  // extra cycles model the refetch after a taken branch or skip
  always_comb begin
    case (state_reg)
      BSC_ST_IDLE: state_next = start ? BSC_ST_EXEC : BSC_ST_IDLE;
      BSC_ST_EXEC: begin
        if (!taken) begin
          state_next = BSC_ST_IDLE;
        end else if (is_skip && long_reg) begin
          state_next = BSC_ST_EXTRA;
        end else begin
          state_next = BSC_ST_LAST;
        end
      end
      BSC_ST_EXTRA: state_next = BSC_ST_LAST;
      BSC_ST_LAST: state_next = BSC_ST_IDLE;
      default: state_next = BSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= BSC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // instruction latch
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      op_reg <= BSC_OP_NOP;
      long_reg <= 1'b0;
      bidx_reg <= 3'h0;
    end else if (wr_en && hit_ctrl && !busy) begin
      op_reg <= bsc_op_type'(PWDATA[`BSC_CTRL_OP_MSB:`BSC_CTRL_OP_LSB]);
      long_reg <= PWDATA[`BSC_CTRL_LONG];
      bidx_reg <= PWDATA[`BSC_CTRL_BIDX_MSB:`BSC_CTRL_BIDX_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_val_reg <= `BSC_RST_BYTE;
      rr_val_reg <= `BSC_RST_BYTE;
      io_val_reg <= `BSC_RST_BYTE;
    end else if (wr_en && hit_opnd && !busy) begin
      rd_val_reg <= PWDATA[`BSC_OPND_RD_MSB:`BSC_OPND_RD_LSB];
      rr_val_reg <= PWDATA[`BSC_OPND_RR_MSB:`BSC_OPND_RR_LSB];
      io_val_reg <= PWDATA[`BSC_OPND_IO_MSB:`BSC_OPND_IO_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      offs_reg <= '0;
    end else if (wr_en && hit_offs && !busy) begin
      offs_reg <= PWDATA[OFFSET_W-1:0];
    end
  end

  // status register and pc: software writes only while idle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_register_reg <= `BSC_RST_STATUS_REGISTER;
    end else if (exec) begin
      status_register_reg <= status_register_exec;
    end else if (wr_en && hit_stat && !busy) begin
      status_register_reg <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_reg <= '0;
    end else if (exec) begin
      pc_reg <= pc_exec;
    end else if (wr_en && hit_pc && !busy) begin
      pc_reg <= PWDATA[PC_W-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      taken_reg <= 1'b0;
      cyc_reg <= 2'h0;
    end else if (exec) begin
      taken_reg <= taken;
      cyc_reg <= cyc_exec;
    end
  end

  // read data selection
  logic [31:0] rd_ctrl;
  logic [31:0] rd_opnd;
  logic [31:0] rd_rslt;
  logic [31:0] rd_mux;
  assign rd_ctrl = {13'h0000, bidx_reg, 7'h00, long_reg, 3'h0, op_reg};
  assign rd_opnd = {8'h00, io_val_reg, rr_val_reg, rd_val_reg};
  assign rd_rslt = {22'h000000, cyc_reg, 6'h00, taken_reg, busy};
  assign rd_mux = hit_ctrl ? rd_ctrl :
                  hit_opnd ? rd_opnd :
                  hit_offs ? {{(32-OFFSET_W){1'b0}}, offs_reg} :
                  hit_stat ? {24'h000000, status_register_reg} :
                  hit_pc ? {{(32-PC_W){1'b0}}, pc_reg} :
                  hit_rslt ? rd_rslt : 32'h00000000;

  // unmapped address answers with an error and zero data
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access & ~hit_any;
      prdata_reg <= (access & ~PWRITE) ? rd_mux : 32'h00000000;
    end
  end

  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign PRDATA = prdata_reg;

endmodule : bsc_unit

// ===== bsc_regs.svh
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

// register byte addresses
`define BSC_ADDR_CTRL 8'h00
`define BSC_ADDR_OPND 8'h04
`define BSC_ADDR_OFFS 8'h08
`define BSC_ADDR_STAT 8'h0c
`define BSC_ADDR_PC 8'h10
`define BSC_ADDR_RSLT 8'h14

// control word fields
`define BSC_CTRL_OP_LSB 0
`define BSC_CTRL_OP_MSB 4
`define BSC_CTRL_LONG 8
`define BSC_CTRL_BIDX_LSB 16
`define BSC_CTRL_BIDX_MSB 18
`define BSC_CTRL_START 31

// operand word fields
`define BSC_OPND_RD_LSB 0
`define BSC_OPND_RD_MSB 7
`define BSC_OPND_RR_LSB 8
`define BSC_OPND_RR_MSB 15
`define BSC_OPND_IO_LSB 16
`define BSC_OPND_IO_MSB 23

// result word fields
`define BSC_RSLT_BUSY 0
`define BSC_RSLT_TAKEN 1
`define BSC_RSLT_CYC_LSB 8
`define BSC_RSLT_CYC_MSB 9

// status register bit positions
`define BSC_SR_C 0
`define BSC_SR_Z 1
`define BSC_SR_N 2
`define BSC_SR_V 3
`define BSC_SR_S 4
`define BSC_SR_H 5
`define BSC_SR_T 6
`define BSC_SR_I 7

// reset values
`define BSC_RST_STATUS_REGISTER 8'h00
`define BSC_RST_BYTE 8'h00

// cycle counts per outcome
`define BSC_CYC_PLAIN 2'h1
`define BSC_CYC_TAKEN 2'h2
`define BSC_CYC_SKIP1 2'h2
`define BSC_CYC_SKIP2 2'h3

`endif

// ===== bsc_pkg.sv
package bsc_pkg;

  typedef enum logic [4:0] {
    BSC_OP_NOP = 5'h00,
    BSC_OP_COMPARE_SKIP_EQUAL = 5'h01,
    BSC_OP_COMPARE_REGS = 5'h02,
    BSC_OP_COMPARE_REGS_CARRY = 5'h03,
    BSC_OP_COMPARE_IMMEDIATE = 5'h04,
    BSC_OP_SKIP_REG_BIT_CLEAR = 5'h05,
    BSC_OP_SKIP_REG_BIT_SET = 5'h06,
    BSC_OP_SKIP_IO_BIT_CLEAR = 5'h07,
    BSC_OP_SKIP_IO_BIT_SET = 5'h08,
    BSC_OP_BRANCH_FLAG_SET = 5'h09,
    BSC_OP_BRANCH_FLAG_CLEAR = 5'h0a,
    BSC_OP_BRANCH_CARRY_CLEAR = 5'h0b,
    BSC_OP_BRANCH_SAME_HIGHER = 5'h0c,
    BSC_OP_BRANCH_SIGNED_GE = 5'h0d,
    BSC_OP_BRANCH_SIGNED_LT = 5'h0e,
    BSC_OP_BRANCH_HALFCARRY_SET = 5'h0f,
    BSC_OP_BRANCH_HALFCARRY_CLEAR = 5'h10,
    BSC_OP_BRANCH_BITSTORE_SET = 5'h11,
    BSC_OP_BRANCH_BITSTORE_CLEAR = 5'h12,
    BSC_OP_BRANCH_OVERFLOW_SET = 5'h13
  } bsc_op_type;

  // gray along idle -> exec -> extra -> last
  typedef enum logic [1:0] {
    BSC_ST_IDLE = 2'h0,
    BSC_ST_EXEC = 2'h1,
    BSC_ST_EXTRA = 2'h3,
    BSC_ST_LAST = 2'h2
  } bsc_state_type;

endpackage : bsc_pkg

// ===== bsc_bit_pick.sv
`timescale 1ns/1ns
module bsc_bit_pick #(
  parameter int W = 8
) (
  input wire logic [W-1:0] value,
  input wire logic [$clog2(W)-1:0] idx,
  output logic bit_out
);
  assign bit_out = value[idx];
endmodule : bsc_bit_pick

// ===== bsc_compare.sv
`timescale 1ns/1ns
module bsc_compare (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic use_carry,
  input wire logic c_in,
  input wire logic z_in,
  output logic c_out,
  output logic z_out,
  output logic n_out,
  output logic v_out,
  output logic h_out
);
  logic [7:0] diff;
  logic zero;
  assign diff = a - b - {7'h00, use_carry & c_in};
  assign zero = (diff == 8'h00);
  // borrow out of bit 7 and bit 3
  assign c_out = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
  assign h_out = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
  assign v_out = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
  assign n_out = diff[7];
  // carry form chains multi-byte compares: zero only if all bytes were zero
  assign z_out = use_carry ? (zero & z_in) : zero;
endmodule : bsc_compare

// ===== bsc_unit_sva.sv
`timescale 1ns/1ns
module bsc_unit_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire acc = PSEL && PENABLE && !PREADY;
  wire rd_rslt = PREADY && !PWRITE && PADDR == 8'h14 && !PRDATA[0];
  a_ready_one_wait: assert property (acc |=> PREADY)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_ready_cause: assert property (PREADY |-> $past(acc))
    else $error("ready without access");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_err_unmapped: assert property (acc && PADDR >= 8'h18 |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (acc && PADDR <= 8'h14 && PADDR[1:0] == 2'h0 |=> !PSLVERR)
    else $error("mapped access refused");
  a_idle_data_zero: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  a_skip_cycles: assert property (
    rd_rslt && PRDATA[1] |-> PRDATA[9:8] == 2'h2 || PRDATA[9:8] == 2'h3)
    else $error("taken outcome with wrong cycle count");
  a_plain_cycles: assert property (
    rd_rslt && !PRDATA[1] && PRDATA[9:8] != 2'h0 |-> PRDATA[9:8] == 2'h1)
    else $error("plain outcome with wrong cycle count");
  a_start_reads_zero: assert property (PREADY && !PWRITE && PADDR == 8'h00 |-> !PRDATA[31])
    else $error("start bit read back");
  c_long_skip: cover property (rd_rslt && PRDATA[9:8] == 2'h3);
  c_taken: cover property (rd_rslt && PRDATA[1]);
  c_refused: cover property (PSLVERR);
endmodule : bsc_unit_chk

bind bsc_unit bsc_unit_chk chk_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR));

// ===== test_branch_skip_compare_unit.sv
`timescale 1ns/1ns
module test_branch_skip_compare_unit;
  import bsc_pkg::*;
  logic CLK, RST_N, PSEL, PENABLE, PWRITE, PSLVERR, PREADY, er;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  int errors = 0;
  int total_checks = 0;
  bsc_unit dut_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  // idle edge after release keeps psel from being assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    if (n >= 20) errors++;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
  endtask : apb
  task automatic run(input logic [4:0] op, input logic lng, input logic [2:0] b,
      input logic [31:0] opnd, input logic [7:0] k, input logic [7:0] st,
      input logic [15:0] xpc, input logic tk, input logic [1:0] cy, input logic [7:0] xst);
    int n;
    apb(1, 8'h04, opnd);
    apb(1, 8'h08, {24'h0, k});
    apb(1, 8'h0c, {24'h0, st});
    apb(1, 8'h10, 32'h0100);
    apb(1, 8'h00, {1'b1, 12'h0, b, 7'h0, lng, 3'h0, op});
    n = 0;
    do begin
      apb(0, 8'h14, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 10);
    chk("rslt", {22'h0, cy, 6'h0, tk, 1'b0}, rd);
    apb(0, 8'h10, 0);
    chk("pc", {16'h0, xpc}, rd);
    apb(0, 8'h0c, 0);
    chk("stat", {24'h0, xst}, rd);
  endtask : run
  // borrows taken from wide subtraction, independent of the gate form
  function automatic logic [7:0] cmpf(input logic [7:0] st, a, b, input logic wc);
    logic [8:0] w;
    logic [4:0] q;
    logic ci;
    logic v;
    ci = wc & st[0];
    w = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    q = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    v = (a[7] ^ b[7]) & (w[7] ^ a[7]);
    return {st[7:6], q[4], st[4], v, w[7], (w[7:0] == 8'h00) & (~wc | st[1]), w[8]};
  endfunction : cmpf
  task automatic cmp(input logic [4:0] op, input logic [7:0] a, b, st, input logic wc);
    run(op, 0, 0, {16'h0, b, a}, 0, st, 16'h0101, 0, 2'h1, cmpf(st, a, b, wc));
  endtask : cmp
  function automatic logic btk(input logic [4:0] op, input logic [7:0] s, input logic [2:0] b);
    case (op)
      5'h09: return s[b];
      5'h0a: return !s[b];
      5'h0b, 5'h0c: return !s[0];
      5'h0d: return !(s[2] ^ s[3]);
      5'h0e: return s[2] ^ s[3];
      5'h0f: return s[5];
      5'h10: return !s[5];
      5'h11: return s[6];
      5'h12: return !s[6];
      default: return s[3];
    endcase
  endfunction : btk
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
  initial begin
    logic [7:0] s, k, r;
    logic [4:0] op;
    logic [2:0] b;
    logic [15:0] p;
    logic [1:0] c;
    logic t;
    RST_N = 0;
    PSEL = 0;
    PENABLE = 0;
    PWRITE = 0;
    PADDR = 0;
    PWDATA = 0;
    repeat (6) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    apb(0, 8'h0c, 0);
    chk("stat_rst", 0, rd);
    apb(0, 8'h10, 0);
    chk("pc_rst", 0, rd);
    apb(0, 8'h18, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    run(5'h00, 0, 3'h0, 0, 0, 8'hc3, 16'h0101, 0, 2'h1, 8'hc3);
    run(5'h14, 1, 3'h5, 0, 0, 8'h3c, 16'h0101, 0, 2'h1, 8'h3c);
    apb(0, 8'h00, 0);
    chk("ctrl", 32'h0005_0114, rd);
    cmp(5'h02, 8'h80, 8'h01, 8'h00, 0);
    cmp(5'h03, 8'h11, 8'h10, 8'h03, 1);
    cmp(5'h03, 8'h00, 8'h00, 8'h01, 1);
    cmp(5'h04, 8'h10, 8'h01, 8'hd0, 0);
    for (int o = 9; o <= 19; o++) begin
      for (int i = 0; i < 3; i++) begin
        s = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h55;
        k = i[0] ? 8'h40 : 8'h3f;
        b = o[2:0];
        t = btk(o[4:0], s, b);
        p = t ? 16'h0101 + {{9{k[6]}}, k[6:0]} : 16'h0101;
        c = t ? 2'h2 : 2'h1;
        run(o[4:0], 0, b, 0, k, s, p, t, c, s);
      end
    end
    for (int o = 0; o < 5; o++) begin
      for (int i = 0; i < 4; i++) begin
        op = (o == 0) ? 5'h01 : 5'(o + 4);
        r = i[1] ? 8'h5a : 8'ha5;
        t = (op == 5'h05 || op == 5'h07) ? !i[1] : i[1];
        p = t ? 16'h0102 + i[0] : 16'h0101;
        c = t ? 2'h2 + i[0] : 2'h1;
        run(op, i[0], 3'h1, {8'h0, r, r, 8'h5a}, 0, 8'h55,
            p, t, c, 8'h55);
      end
    end
    end_of_test();
  end
endmodule : test_branch_skip_compare_unit
